//--- design/sbio_parallel_port.sv
// serial bit bus slave: 16 parallel i/o bits plus interrupt control
// Overview of operation
// - decode 32 positions at bases 0100, 0120
// - upper 16 positions are individually accessed i/o
// - serial written bits appear in parallel on pins
// - pin levels returned serially one bit per access
// - lower 16 give mask, timer, restore-to-input
// - request lines 1 to 14 each gated by its mask bit
// - unmasked request encoded onto four code lines
// - request line low when unmasked, never at reset
`timescale 1ns/1ps
`include "sbio_regs.svh"

module sbio_parallel_port (
	input wire logic clk_i, // 200 MHz system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic [`SBIO_ADDR_W-1:0] bit_addr_i, // bus bit address
	input wire logic bit_wr_i, // one-cycle write strobe
	input wire logic bit_wr_data_i, // serial data from host
	output logic bit_rd_data_o, // serial data to host, registered
	input wire logic [`SBIO_PIO_W-1:0] pio_in_i, // i/o pin levels
	output logic [`SBIO_PIO_W-1:0] pio_out_o, // i/o pin drive value
	output logic [`SBIO_PIO_W-1:0] pio_oe_o, // i/o drive enables
	input wire logic [`SBIO_PIO_W-1:0] irq_i, // request lines, high
	output logic timer_sel_o, // timer control bit
	output logic [`SBIO_CODE_W-1:0] int_code_o, // interrupt code lines
	output logic interrupt_request_n_o // request to host, active low
);

	sbio_pkg::sbio_state_t st;
	sbio_pkg::sbio_state_t next_st;
	logic [`SBIO_PIO_W-1:0] pin_s;
	logic [`SBIO_PIO_W-1:0] irq_s;
	logic [`SBIO_POS_W-1:0] pos;
	logic sel_low;
	logic sel_high;
	logic [`SBIO_INT_HI:`SBIO_INT_LO] pend;
	logic rd_expect;

	// pins and request lines come from outside the clock domain
	sbio_sync u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(pio_in_i),
		.sync_o(pin_s)
	);

	// request lines 0 and 15 are synchronised but never used
	sbio_sync u_irq_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(irq_i),
		.sync_o(irq_s)
	);

	assign pos = bit_addr_i[`SBIO_POS_W-1:0];
	// only the bits above the position field take part, at full width
	assign sel_low = ((bit_addr_i >> `SBIO_BLOCK_LSB) ==
		(`SBIO_LOW_BASE >> `SBIO_BLOCK_LSB));
	assign sel_high = ((bit_addr_i >> `SBIO_BLOCK_LSB) ==
		(`SBIO_HIGH_BASE >> `SBIO_BLOCK_LSB));
	assign pend = irq_s[`SBIO_INT_HI:`SBIO_INT_LO] & st.mask;
	assign rd_expect = pin_s[pos];

	always_comb begin
		next_st = st;
		if (bit_wr_i && sel_high) begin
			next_st.pio_out[pos] = bit_wr_data_i;
			// a pin once written stays driven until restore or reset
			next_st.pio_oe[pos] = 1'b1;
		end
		if (bit_wr_i && sel_low) begin
			case (pos)
				`SBIO_POS_TIMER: begin
					next_st.timer_sel = bit_wr_data_i;
				end
				`SBIO_POS_RESTORE: begin
					// a one floats every pin; a zero does nothing
					if (bit_wr_data_i) begin
						next_st.pio_oe = '0;
					end
				end
				default: begin
					next_st.mask[pos] = bit_wr_data_i;
				end
			endcase
		end
		// a position written in the same cycle reads back its old value
		// read is sampled every cycle, valid one cycle after the address
		if (sel_high) begin
			next_st.rd_bit = rd_expect;
		end else if (sel_low) begin
			case (pos)
				`SBIO_POS_TIMER: next_st.rd_bit = st.timer_sel;
				`SBIO_POS_RESTORE: next_st.rd_bit = 1'b0;
				default: next_st.rd_bit = st.mask[pos];
			endcase
		end else begin
			next_st.rd_bit = 1'b0;
		end
		// lowest numbered unmasked request wins
		next_st.int_code = `SBIO_CODE_NONE;
		for (int i = `SBIO_INT_HI; i >= `SBIO_INT_LO; i--) begin
			if (pend[i]) begin
				next_st.int_code = i[`SBIO_CODE_W-1:0];
			end
		end
		next_st.int_req_n = ~|pend;
	end

	// reset holds the request line high: reset is not an interrupt
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.int_req_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign bit_rd_data_o = st.rd_bit;
	assign pio_out_o = st.pio_out;
	assign pio_oe_o = st.pio_oe;
	assign timer_sel_o = st.timer_sel;
	assign int_code_o = st.int_code;
	assign interrupt_request_n_o = st.int_req_n;

	// assertions stay quiet while reset is held, unless they say otherwise
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_NO_DECODE: assert property (
		(bit_wr_i && !sel_low && !sel_high) |=>
		($stable(pio_out_o) && $stable(pio_oe_o) && $stable(timer_sel_o)))
		else $error("write outside window changed state");
	AST_OUT_WRITE: assert property (
		(bit_wr_i && sel_high) |=>
		(pio_out_o[$past(pos)] == $past(bit_wr_data_i)))
		else $error("pin value not taken from serial bit");
	AST_OE_WRITE: assert property (
		(bit_wr_i && sel_high) |=> pio_oe_o[$past(pos)])
		else $error("written pin not driven");
	AST_READ_PIN: assert property (
		sel_high |=> (bit_rd_data_o == $past(rd_expect)))
		else $error("read bit differs from pin level");
	AST_RESTORE: assert property (
		(bit_wr_i && sel_low && pos == `SBIO_POS_RESTORE && bit_wr_data_i)
		|=> (pio_oe_o == '0))
		else $error("restore did not float the pins");
	AST_TIMER: assert property (
		(bit_wr_i && sel_low && pos == `SBIO_POS_TIMER) |=>
		(timer_sel_o == $past(bit_wr_data_i)))
		else $error("timer bit not written");
	AST_MASKED: assert property (
		(pend == '0) |=> (interrupt_request_n_o &&
		int_code_o == `SBIO_CODE_NONE))
		else $error("masked request reached the host");
	AST_REQ: assert property (
		(pend != '0) |=> (!interrupt_request_n_o &&
		int_code_o != `SBIO_CODE_NONE))
		else $error("unmasked request not signalled");
	AST_CODE_HI: assert property (
		(pend[`SBIO_INT_LO]) |=> (int_code_o == `SBIO_INT_LO))
		else $error("highest priority code wrong");

	// pin value and timer hold without a decoded write, pin drive drops only on a restore, and a mask write must land
	AST_OUT_HOLD: assert property (
		!(bit_wr_i && sel_high) |=> $stable(pio_out_o))
		else $error("pin value changed without a write");
	AST_OE_HOLD: assert property (
		!(bit_wr_i && sel_low && pos == `SBIO_POS_RESTORE &&
		bit_wr_data_i) |=>
		((pio_oe_o & $past(pio_oe_o)) == $past(pio_oe_o)))
		else $error("pin drive dropped without a restore");
	AST_TIMER_HOLD: assert property (
		!(bit_wr_i && sel_low && pos == `SBIO_POS_TIMER) |=>
		$stable(timer_sel_o))
		else $error("timer bit changed without a write");
	AST_MASK_WRITE: assert property (
		(bit_wr_i && sel_low && pos != `SBIO_POS_TIMER &&
		pos != `SBIO_POS_RESTORE) |=>
		(st.mask[$past(pos)] == $past(bit_wr_data_i)))
		else $error("mask bit not written");

	// every address answers one cycle later, inside or outside the window
	AST_READ_TIMER: assert property (
		(sel_low && pos == `SBIO_POS_TIMER) |=>
		(bit_rd_data_o == $past(timer_sel_o)))
		else $error("timer bit read back wrong");
	AST_READ_MASK: assert property (
		(sel_low && pos != `SBIO_POS_TIMER &&
		pos != `SBIO_POS_RESTORE) |=>
		(bit_rd_data_o == $past(st.mask[pos])))
		else $error("mask bit read back wrong");
	AST_READ_RESTORE: assert property (
		(sel_low && pos == `SBIO_POS_RESTORE) |=> !bit_rd_data_o)
		else $error("restore position did not read zero");
	AST_READ_NONE: assert property (
		(!sel_low && !sel_high) |=> !bit_rd_data_o)
		else $error("read outside window not zero");

	// reset itself is watched, so the first check switches the default disable off
	AST_RESET_REQ: assert property (
		disable iff (1'b0) !rst_n_i |=> interrupt_request_n_o)
		else $error("request line low after reset");
	AST_CODE_RANGE: assert property (
		!interrupt_request_n_o |->
		(int_code_o >= `SBIO_INT_LO && int_code_o <= `SBIO_INT_HI))
		else $error("code out of request range");
	AST_CODE_LOW: assert property (
		(pend != '0) |=> (($past({pend, 1'b0}) &
		-$past({pend, 1'b0})) == (15'h1 << int_code_o)))
		else $error("code is not the lowest unmasked request");

endmodule

//--- design/sbio_regs.svh
// bit positions, decode bases and widths of the serial bit i/o port
`ifndef SBIO_REGS_SVH
`define SBIO_REGS_SVH

`define SBIO_ADDR_W 12
`define SBIO_PIO_W 16
`define SBIO_POS_W 4
`define SBIO_INT_HI 14
`define SBIO_INT_LO 1
`define SBIO_CODE_W 4
// hardware bit addresses: software base 0100 and 0120 divided by two
`define SBIO_LOW_BASE 12'h080
`define SBIO_HIGH_BASE 12'h090
`define SBIO_BLOCK_LSB 4
`define SBIO_POS_TIMER 4'h0
`define SBIO_POS_RESTORE 4'hf
`define SBIO_CODE_NONE 4'h0
`define SBIO_SYNC_STAGES 2

`endif

//--- design/sbio_pkg.sv
// types of the serial bit i/o port
`include "sbio_regs.svh"

package sbio_pkg;

	typedef struct packed {
		logic [`SBIO_PIO_W-1:0] pio_out;
		logic [`SBIO_PIO_W-1:0] pio_oe;
		logic [`SBIO_INT_HI:`SBIO_INT_LO] mask;
		logic timer_sel;
		logic rd_bit;
		logic [`SBIO_CODE_W-1:0] int_code;
		logic int_req_n;
	} sbio_state_t;

	typedef struct packed {
		logic [`SBIO_PIO_W-1:0] meta;
		logic [`SBIO_PIO_W-1:0] stable;
	} sbio_sync_state_t;

endpackage

//--- design/sbio_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`include "sbio_regs.svh"

module sbio_sync (
	input wire logic clk_i, // system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic [`SBIO_PIO_W-1:0] async_i, // raw pin levels
	output logic [`SBIO_PIO_W-1:0] sync_o // synchronised levels
);

	sbio_pkg::sbio_sync_state_t st;
	sbio_pkg::sbio_sync_state_t next_st;

	// meta feeds only the second stage
	always_comb begin
		next_st.meta = async_i;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_o = st.stable;

endmodule

//--- bench/sbio_host.sv
// host model: serialises bit bus transfers
`timescale 1ns/1ps
`include "sbio_regs.svh"
module sbio_host (
	input wire logic clk_i, // system clock
	output logic [11:0] addr_o, // bit address
	output logic wr_o, // write strobe
	output logic wd_o, // write data
	input wire logic rd_i // read data
);
	initial begin
		addr_o = 12'h000;
		wr_o = 1'b0;
		wd_o = 1'b0;
	end
	// lsb at the base, one bit a strobe
	task automatic put(input logic [11:0] a, input logic [15:0] v,
		input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_i);
			addr_o = a + 12'(i);
			wr_o = 1'b1;
			wd_o = v[i];
		end
		@(negedge clk_i);
		wr_o = 1'b0;
		// released data line shows no stale bit
		wd_o = ~wd_o;
	endtask
	task automatic get(input logic [11:0] a, output logic [15:0] v);
		v = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			@(negedge clk_i);
			addr_o = a + 12'(i);
			@(negedge clk_i);
			v[i] = rd_i;
		end
	endtask
	// one to eight bits land in the left byte of the word
	task automatic get_part(input logic [11:0] a, input int n,
		output logic [15:0] v);
		v = 16'h0000;
		for (int i = 0; i < n; i++) begin
			@(negedge clk_i);
			addr_o = a + 12'(i);
			@(negedge clk_i);
			if (n <= 8)
				v[8 + i] = rd_i;
			else
				v[i] = rd_i;
		end
	endtask
	// base pointer bits 1..12 give the address
	// the displacement is sign-extended and added
	task automatic sbit(input logic [15:0] r, input logic [7:0] d,
		input logic val);
		@(negedge clk_i);
		addr_o = r[12:1] + {{4{d[7]}}, d};
		wr_o = 1'b1;
		wd_o = val;
		@(negedge clk_i);
		wr_o = 1'b0;
		wd_o = ~wd_o;
	endtask
	// equal status is set by a one and cleared by a zero
	task automatic tst(input logic [15:0] r, input logic [7:0] d,
		output logic eq);
		@(negedge clk_i);
		addr_o = r[12:1] + {{4{d[7]}}, d};
		@(negedge clk_i);
		eq = (rd_i == 1'b1);
	endtask
endmodule

//--- bench/tb_sbio_parallel_port.sv
// self-checking bench of the serial bit i/o port
`timescale 1ns/1ps
`include "sbio_regs.svh"
module tb_sbio_parallel_port;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [11:0] a;
	logic w, wd, rd, ts, rq, eq;
	logic [15:0] pin = 16'h0000, irq = 16'h0000, po, oe, v, eo, ee, x;
	logic [3:0] code;
	int fails = 0, check_count = 0, cyc = 0, seed = 96684, n, b, c;
	always #2.5 clk_i = ~clk_i;
	sbio_host host (.clk_i(clk_i), .addr_o(a), .wr_o(w), .wd_o(wd),
		.rd_i(rd));
	sbio_parallel_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.bit_addr_i(a), .bit_wr_i(w), .bit_wr_data_i(wd),
		.bit_rd_data_o(rd), .pio_in_i(pin), .pio_out_o(po),
		.pio_oe_o(oe), .irq_i(irq), .timer_sel_o(ts),
		.int_code_o(code), .interrupt_request_n_o(rq));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		eo = 16'h0000;
		ee = 16'h0000;
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		chk({ts, rq, code, oe}, 22'h10_0000);
		for (int k = 0; k < 6; k++) begin
			n = 1 + ($random(seed) & 15);
			b = ($random(seed) & 15) % (17 - n);
			v = 16'($random(seed));
			host.put(`SBIO_HIGH_BASE + 12'(b), v, n);
			for (int i = 0; i < n; i++) begin
				eo[b + i] = v[i];
				ee[b + i] = 1'b1;
			end
			host.put(12'h0a0, 16'hffff, 1);
			host.put(12'h07f, 16'hffff, 1);
			chk(po, eo);
			chk(oe, ee);
			pin = 16'($random(seed));
			repeat (3) @(negedge clk_i);
			host.get(`SBIO_HIGH_BASE, v);
			chk(v, pin);
		end
		for (int k = 0; k < 5; k++) begin
			x = 16'($random(seed)) & 16'h7fff;
			irq = 16'($random(seed));
			host.put(`SBIO_LOW_BASE, x, 15);
			c = 0;
			for (int i = 14; i > 0; i--)
				if (x[i] && irq[i])
					c = i;
			repeat (4) @(negedge clk_i);
			chk({ts, code}, {x[0], 4'(c)});
			chk(rq, c == 0);
			host.get(`SBIO_LOW_BASE, v);
			chk(v, x);
		end
		for (int k = 0; k < 4; k++) begin
			b = $random(seed) & 15;
			n = 1 + ($random(seed) & 7);
			v = 16'($random(seed));
			host.sbit(16'h0140, 8'(b - 16), v[0]);
			chk({oe[b], po[b]}, {1'b1, v[0]});
			pin = v;
			repeat (3) @(negedge clk_i);
			host.tst(16'h0120, 8'(b), eq);
			chk(eq, pin[b]);
			host.get_part(`SBIO_HIGH_BASE, n, x);
			eo = {8'(pin & ~(16'hffff << n)), 8'h00};
			chk(x, eo);
		end
		host.put(`SBIO_LOW_BASE + 12'h00f, 16'h0001, 1);
		chk(oe, 16'h0000);
		irq = 16'h0002;
		host.put(`SBIO_LOW_BASE + 12'h001, 16'h0001, 1);
		repeat (4) @(negedge clk_i);
		chk({rq, code}, 5'h01);
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk({rq, code}, 5'h10);
		rst_n_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({ts, rq, code, oe}, 22'h10_0000);
		wrap_up();
	end
endmodule
